// [ats_pkg.sv]
package ats_pkg;

	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int unsigned WORD_W     = 32;
	localparam int unsigned FLAG_W     = 24;
	localparam int unsigned MODE_W     = 8;
	localparam int unsigned ADDR_W_DEF = 24;

	// ------------------------------------------------------------------
	// low-memory trap vectors (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [11:0] VEC_HOST_END = 12'h2e0;
	localparam logic [11:0] VEC_START    = 12'h2e4;
	localparam logic [11:0] VEC_SUPV     = 12'h2e8;
	localparam logic [11:0] VEC_ERROR    = 12'h2ec;
	localparam logic [11:0] VEC_MONITOR  = 12'h2f0;
	localparam logic [11:0] VEC_STOP     = 12'h2f4;

	// ------------------------------------------------------------------
	// context block word offsets (byte offsets from block start)
	// ------------------------------------------------------------------
	localparam logic [4:0] CTX_OLD_HI = 5'h00;
	localparam logic [4:0] CTX_OLD_LO = 5'h04;
	localparam logic [4:0] CTX_NEW_HI = 5'h08;
	localparam logic [4:0] CTX_NEW_LO = 5'h0c;
	localparam logic [4:0] CTX_STATUS = 5'h10;

	// ------------------------------------------------------------------
	// status word layout (bit 0 = lsb)
	// ------------------------------------------------------------------
	localparam int unsigned STAT_FLAG_LSB  = 8;
	localparam int unsigned FLAG_UNDEF_BIT = 9;
	localparam int unsigned MODE_ARITH_BIT = 7;
	localparam int unsigned MODE_TOFF_BIT  = 6;
	localparam int unsigned MODE_BLOCK_BIT = 5;
	localparam int unsigned MODE_DW_BIT    = 0;
	localparam logic [FLAG_W-1:0] FLAG_RESET = 24'h000000;

	// ------------------------------------------------------------------
	// supervisor call selector position in the instruction word
	// ------------------------------------------------------------------
	localparam int unsigned SUPV_SEL_LSB = 12;
	localparam int unsigned SUPV_SEL_W   = 4;

	typedef enum logic [2:0] {
		ATS_OP_PLAIN,
		ATS_OP_INTRET,
		ATS_OP_IO,
		ATS_OP_INTCTL,
		ATS_OP_UNBLOCK
	} ats_op_e;

	typedef enum logic [2:0] {
		ATS_TRAP_START,
		ATS_TRAP_ERROR,
		ATS_TRAP_STOP,
		ATS_TRAP_MONITOR,
		ATS_TRAP_SUPV
	} ats_trap_e;

endpackage

// [ats_mem_if.sv]
`timescale 1ns/100ps
interface ats_mem_if #(
	parameter int unsigned ADDR_W = 24
);
	logic              valid;
	logic              ready;
	logic              we;
	logic [ADDR_W-1:0] addr;
	logic [31:0]       wdata;
	logic              done;
	logic [31:0]       rdata;

	modport seq (
		output valid, we, addr, wdata,
		input  ready, done, rdata
	);
	modport port (
		input  valid, we, addr, wdata,
		output ready, done, rdata
	);
endinterface

// [ats_mem_port.sv]
`timescale 1ns/100ps
module ats_mem_port #(
	parameter int unsigned ADDR_W = 24
) (
	// clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_in,
	// sequencer side
	ats_mem_if.port                cmd,
	// memory side
	output logic                   mem_req_out,
	output logic                   mem_we_out,
	output logic [ADDR_W-1:0]      mem_addr_out,
	output logic [31:0]            mem_wdata_out,
	input  wire logic              mem_ack_in,
	input  wire logic [31:0]       mem_rdata_in
);

	logic        req_q;
	logic        done_q;
	logic [31:0] rdata_q;

	// one access at a time; a new one is taken only when idle
	assign cmd.ready = !req_q;
	assign cmd.done  = done_q;
	assign cmd.rdata = rdata_q;
	assign mem_req_out = req_q;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			req_q         <= 1'b0;
			mem_we_out    <= 1'b0;
			mem_addr_out  <= '0;
			mem_wdata_out <= 32'h00000000;
		end else if (!req_q && cmd.valid) begin
			req_q         <= 1'b1;
			mem_we_out    <= cmd.we;
			mem_addr_out  <= cmd.addr;
			mem_wdata_out <= cmd.wdata;
		end else if (req_q && mem_ack_in) begin
			req_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			done_q  <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			done_q <= req_q && mem_ack_in;
			if (req_q && mem_ack_in && !mem_we_out)
				rdata_q <= mem_rdata_in;
		end
	end

endmodule // ats_mem_port

// [ats_trap_seq.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - done pulse raises host end-of-processing trap
// - own traps use vectors 2e4 through 2f4
// - runs only in status-doubleword mode
// - refuse interrupt return, io, interrupt control
// - trap entry never tied to service interrupt
// - block words 1-4 doublewords, word 5 status
// - keeps a 32-bit status word
// - read-status copies word to named register
// - error trap stores status in word five
// - error flags clear after any report
// - mode field live, never cleared
// - host signal starts with new doubleword
// - start: fetch pointer, save old, status
// - then load words 3, 4 and run
// - signal while active aborts, saves old doubleword
// - restart saves status then runs new doubleword
// - end trap only after signalled work finishes
// - done after stores, before loading new doubleword
// - quiescent after reset until host signal
// - supervisor call picks one of 16 vectors
module ats_trap_seq #(
	parameter int unsigned ADDR_W = ats_pkg::ADDR_W_DEF
) (
	// clock and reset
	input  wire logic                     mclk_in,
	input  wire logic                     rst_in,
	// host signal lines
	input  wire logic                     host_signal_in,
	output logic                          host_done_out,
	// executing datapath: state and events
	input  wire logic [63:0]              cur_dw_in,
	input  wire logic                     instr_valid_in,
	input  wire ats_pkg::ats_op_e         instr_class_in,
	input  wire logic [31:0]              instr_word_in,
	input  wire logic                     error_trap_in,
	input  wire logic [ats_pkg::FLAG_W-1:0] err_flags_in,
	input  wire logic                     supv_call_in,
	input  wire logic                     monitor_call_in,
	input  wire logic                     stop_signal_in,
	input  wire logic                     read_status_in,
	input  wire logic [2:0]               read_status_reg_in,
	// live mode inputs
	input  wire logic                     block_mode_in,
	input  wire logic                     traps_off_in,
	input  wire logic                     arith_en_in,
	// datapath control
	output logic                          run_out,
	output logic                          instr_refused_out,
	output logic                          new_dw_load_out,
	output logic [63:0]                   new_dw_out,
	output logic                          status_valid_out,
	output logic [2:0]                    status_reg_out,
	output logic [31:0]                   status_out,
	// memory port
	output logic                          mem_req_out,
	output logic                          mem_we_out,
	output logic [ADDR_W-1:0]             mem_addr_out,
	output logic [31:0]                   mem_wdata_out,
	input  wire logic                     mem_ack_in,
	input  wire logic [31:0]              mem_rdata_in
);

	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ats_trap_seq: ADDR_W must lie in 12..32");
	end

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_VEC,
		ST_TABLE,
		ST_SAVE_HI,
		ST_SAVE_LO,
		ST_SAVE_STAT,
		ST_DONE,
		ST_LOAD_HI,
		ST_LOAD_LO,
		ST_RUN
	} ats_state_e;

	ats_state_e             state_q;
	ats_pkg::ats_trap_e     kind_q;
	logic [ADDR_W-1:0]      ctx_q;
	logic [63:0]            old_dw_q;
	logic [31:0]            new_hi_q;
	logic [ats_pkg::FLAG_W-1:0] flags_q;
	logic [ats_pkg::MODE_W-1:0] mode;
	logic [31:0]            status_word;
	logic                   pend_q;
	logic                   restart_q;
	logic [ats_pkg::SUPV_SEL_W-1:0] sel_q;
	logic                   refused;
	logic                   run_trap;
	ats_pkg::ats_trap_e     run_kind;
	logic                   take_restart;
	logic                   mem_state;
	logic                   issue;
	logic                   rd_done;
	logic                   stat_issue;
	logic                   report;
	logic [ADDR_W-1:0]      vec_addr;

	ats_mem_if #(.ADDR_W(ADDR_W)) mem ();

	ats_mem_port #(.ADDR_W(ADDR_W)) u_port (
		.mclk_in       (mclk_in),
		.rst_in        (rst_in),
		.cmd           (mem.port),
		.mem_req_out   (mem_req_out),
		.mem_we_out    (mem_we_out),
		.mem_addr_out  (mem_addr_out),
		.mem_wdata_out (mem_wdata_out),
		.mem_ack_in    (mem_ack_in),
		.mem_rdata_in  (mem_rdata_in)
	);

	// ------------------------------------------------------------------
	// status word
	// ------------------------------------------------------------------
	always_comb begin
		mode = '0;
		mode[ats_pkg::MODE_DW_BIT]    = 1'b1;
		mode[ats_pkg::MODE_BLOCK_BIT] = block_mode_in;
		mode[ats_pkg::MODE_TOFF_BIT]  = traps_off_in;
		mode[ats_pkg::MODE_ARITH_BIT] = arith_en_in;
	end

	assign status_word = {flags_q, mode};

	// refused instruction classes raise undefined-instruction errors
	assign refused = state_q == ST_RUN && instr_valid_in &&
		instr_class_in inside {ats_pkg::ATS_OP_INTRET,
		ats_pkg::ATS_OP_IO, ats_pkg::ATS_OP_INTCTL};
	assign instr_refused_out = refused;

	// a report is the status store into word five or a read-status
	assign stat_issue = issue && state_q == ST_SAVE_STAT;
	assign report     = stat_issue || read_status_in;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_q <= ats_pkg::FLAG_RESET;
		end else begin
			// clear on report, new flags of this cycle still land
			flags_q <= (report ? '0 : flags_q)
				| err_flags_in
				| (refused ? ats_pkg::FLAG_W'(1) <<
					(ats_pkg::FLAG_UNDEF_BIT -
					ats_pkg::STAT_FLAG_LSB) : '0);
		end
	end

	// ------------------------------------------------------------------
	// read-status answer
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			status_valid_out <= 1'b0;
			status_reg_out   <= 3'h0;
			status_out       <= 32'h00000000;
		end else begin
			status_valid_out <= read_status_in;
			if (read_status_in) begin
				status_reg_out <= read_status_reg_in;
				status_out     <= status_word;
			end
		end
	end

	// ------------------------------------------------------------------
	// trap selection while running
	// ------------------------------------------------------------------
	always_comb begin
		run_trap = state_q == ST_RUN && (error_trap_in || refused ||
			stop_signal_in || monitor_call_in || supv_call_in);
		if (error_trap_in || refused)
			run_kind = ats_pkg::ATS_TRAP_ERROR;
		else if (stop_signal_in)
			run_kind = ats_pkg::ATS_TRAP_STOP;
		else if (monitor_call_in)
			run_kind = ats_pkg::ATS_TRAP_MONITOR;
		else
			run_kind = ats_pkg::ATS_TRAP_SUPV;
	end

	// restart waits only for an access already on the bus to finish
	assign take_restart = restart_q && (!pend_q || mem.done);

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			restart_q <= 1'b0;
		end else if (host_signal_in) begin
			restart_q <= 1'b1;
		end else if (take_restart) begin
			restart_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// memory access issue
	// ------------------------------------------------------------------
	assign mem_state = !(state_q inside {ST_IDLE, ST_DONE, ST_RUN});

	assign issue   = mem_state && !pend_q && !restart_q && mem.ready;
	assign rd_done = pend_q && mem.done;

	always_comb begin
		unique case (kind_q)
			ats_pkg::ATS_TRAP_START:   vec_addr = ADDR_W'(ats_pkg::VEC_START);
			ats_pkg::ATS_TRAP_ERROR:   vec_addr = ADDR_W'(ats_pkg::VEC_ERROR);
			ats_pkg::ATS_TRAP_STOP:    vec_addr = ADDR_W'(ats_pkg::VEC_STOP);
			ats_pkg::ATS_TRAP_MONITOR: vec_addr = ADDR_W'(ats_pkg::VEC_MONITOR);
			ats_pkg::ATS_TRAP_SUPV:    vec_addr = ADDR_W'(ats_pkg::VEC_SUPV);
			default:                   vec_addr = ADDR_W'(ats_pkg::VEC_ERROR);
		endcase
	end

	always_comb begin
		mem.valid = issue;
		mem.we    = 1'b0;
		mem.addr  = '0;
		mem.wdata = 32'h00000000;
		unique case (state_q)
			ST_VEC:       mem.addr = vec_addr;
			ST_TABLE:     mem.addr = ctx_q + ADDR_W'({sel_q, 2'b00});
			ST_SAVE_HI: begin
				mem.we    = 1'b1;
				mem.addr  = ctx_q + ADDR_W'(ats_pkg::CTX_OLD_HI);
				mem.wdata = old_dw_q[63:32];
			end
			ST_SAVE_LO: begin
				mem.we    = 1'b1;
				mem.addr  = ctx_q + ADDR_W'(ats_pkg::CTX_OLD_LO);
				mem.wdata = old_dw_q[31:0];
			end
			ST_SAVE_STAT: begin
				mem.we    = 1'b1;
				mem.addr  = ctx_q + ADDR_W'(ats_pkg::CTX_STATUS);
				mem.wdata = status_word;
			end
			ST_LOAD_HI:   mem.addr = ctx_q + ADDR_W'(ats_pkg::CTX_NEW_HI);
			ST_LOAD_LO:   mem.addr = ctx_q + ADDR_W'(ats_pkg::CTX_NEW_LO);
			default:      mem.addr = '0;
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pend_q <= 1'b0;
		end else if (issue) begin
			pend_q <= 1'b1;
		end else if (mem.done) begin
			pend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			kind_q  <= ats_pkg::ATS_TRAP_START;
		end else if (take_restart) begin
			// abort whatever runs and vector through the start trap
			state_q <= ST_VEC;
			kind_q  <= ats_pkg::ATS_TRAP_START;
		end else begin
			unique case (state_q)
				ST_IDLE: state_q <= ST_IDLE;
				ST_RUN: begin
					// entered from internal events only
					if (run_trap) begin
						state_q <= ST_VEC;
						kind_q  <= run_kind;
					end
				end
				ST_VEC: begin
					if (rd_done)
						state_q <= (kind_q == ats_pkg::ATS_TRAP_SUPV) ?
							ST_TABLE : ST_SAVE_HI;
				end
				ST_TABLE:   if (rd_done) state_q <= ST_SAVE_HI;
				ST_SAVE_HI: if (rd_done) state_q <= ST_SAVE_LO;
				ST_SAVE_LO: if (rd_done) state_q <= ST_SAVE_STAT;
				ST_SAVE_STAT: begin
					if (rd_done)
						state_q <= (kind_q == ats_pkg::ATS_TRAP_STOP) ?
							ST_DONE : ST_LOAD_HI;
				end
				ST_DONE:    state_q <= ST_LOAD_HI;
				ST_LOAD_HI: if (rd_done) state_q <= ST_LOAD_LO;
				ST_LOAD_LO: if (rd_done) state_q <= ST_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// context pointer, selector and saved doubleword
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ctx_q <= '0;
		end else if (rd_done && (state_q == ST_VEC ||
				state_q == ST_TABLE)) begin
			ctx_q <= {mem.rdata[ADDR_W-1:2], 2'b00};
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sel_q <= '0;
		end else if (state_q == ST_RUN && run_trap &&
				run_kind == ats_pkg::ATS_TRAP_SUPV) begin
			sel_q <= instr_word_in[ats_pkg::SUPV_SEL_LSB +:
				ats_pkg::SUPV_SEL_W];
		end
	end

	// old doubleword captured at the moment of trap entry
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			old_dw_q <= 64'h0000000000000000;
		end else if (take_restart || (state_q == ST_RUN && run_trap)) begin
			old_dw_q <= cur_dw_in;
		end
	end

	// ------------------------------------------------------------------
	// new doubleword delivery and host done
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			new_hi_q        <= 32'h00000000;
			new_dw_out      <= 64'h0000000000000000;
			new_dw_load_out <= 1'b0;
		end else begin
			new_dw_load_out <= 1'b0;
			if (!take_restart && rd_done && state_q == ST_LOAD_HI)
				new_hi_q <= mem.rdata;
			if (!take_restart && rd_done && state_q == ST_LOAD_LO) begin
				new_dw_out      <= {new_hi_q, mem.rdata};
				new_dw_load_out <= 1'b1;
			end
		end
	end

	// the stop trap is the only source of the done signal, so a
	// restart drops the one owed to the aborted work
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			host_done_out <= 1'b0;
		else
			host_done_out <= state_q == ST_DONE && !take_restart;
	end

	assign run_out = state_q == ST_RUN;

endmodule // ats_trap_seq

// [ats_mem_model.sv]
`timescale 1ns/100ps
module ats_mem_model #(
	parameter int unsigned ADDR_W = 24
) (
	// clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_in,
	// request side
	input  wire logic              req_in,
	input  wire logic              we_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [31:0]       wdata_in,
	input  wire logic [3:0]        lat_in,
	// answer side
	output logic                   ack_out,
	output logic [31:0]            rdata_out
);
	logic [31:0] mem [logic [ADDR_W-1:0]];
	logic [3:0]  wait_q;

	// ----------------------------------------------------------------
	// shared memory, host fills words 3 and 4 through mem
	// ----------------------------------------------------------------
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_out   <= 1'b0;
			wait_q    <= 4'h0;
			rdata_out <= 32'h0;
		end else if (req_in && !ack_out && wait_q < lat_in) begin
			wait_q    <= wait_q + 4'h1;
			rdata_out <= ~rdata_out;
		end else if (req_in && !ack_out) begin
			ack_out <= 1'b1;
			wait_q  <= 4'h0;
			if (we_in) begin
				mem[addr_in] = wdata_in;
			end else begin
				rdata_out <= mem.exists(addr_in) ? mem[addr_in] : 32'h0;
			end
		end else begin
			// released bus: data toggles so stale values never match
			ack_out   <= 1'b0;
			rdata_out <= ~rdata_out;
		end
	end
endmodule // ats_mem_model

// [ats_trap_seq_sva.sv]
`timescale 1ns/100ps
module ats_trap_seq_sva #(
	parameter int unsigned ADDR_W = 24
) (
	// clock and reset
	input wire logic               mclk_in,
	input wire logic               rst_in,
	// inputs of the block
	input wire logic               host_signal_in,
	input wire logic               instr_valid_in,
	input wire ats_pkg::ats_op_e   instr_class_in,
	input wire logic               error_trap_in,
	input wire logic [23:0]        err_flags_in,
	input wire logic               read_status_in,
	input wire logic [2:0]         read_status_reg_in,
	input wire logic               block_mode_in,
	input wire logic               traps_off_in,
	input wire logic               arith_en_in,
	input wire logic               mem_ack_in,
	input wire logic [31:0]        mem_rdata_in,
	// outputs of the block
	input wire logic               run_out,
	input wire logic               instr_refused_out,
	input wire logic               new_dw_load_out,
	input wire logic [63:0]        new_dw_out,
	input wire logic               status_valid_out,
	input wire logic [2:0]         status_reg_out,
	input wire logic [31:0]        status_out,
	input wire logic               host_done_out,
	input wire logic               mem_req_out,
	input wire logic               mem_we_out,
	input wire logic [ADDR_W-1:0]  mem_addr_out,
	input wire logic [31:0]        mem_wdata_out
);
	logic        started_q;
	logic [31:0] rd0_q;
	logic [31:0] rd1_q;

	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			started_q <= 1'b0;
		end else if (host_signal_in) begin
			started_q <= 1'b1;
		end
	end

	// last two read words, the new doubleword comes from them
	always_ff @(posedge mclk_in) begin
		if (mem_req_out && !mem_we_out && mem_ack_in) begin
			rd1_q <= rd0_q;
			rd0_q <= mem_rdata_in;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	chk_quiet_idle: assert property (
		!started_q |-> !mem_req_out && !run_out && !host_done_out)
		else $error("activity before host signal");
	chk_refuse_class: assert property (
		run_out && instr_valid_in && instr_class_in inside
		{ats_pkg::ATS_OP_INTRET, ats_pkg::ATS_OP_IO,
		ats_pkg::ATS_OP_INTCTL} |-> instr_refused_out)
		else $error("forbidden class not refused");
	chk_allow_class: assert property (
		instr_valid_in && instr_class_in inside
		{ats_pkg::ATS_OP_PLAIN, ats_pkg::ATS_OP_UNBLOCK}
		|-> !instr_refused_out)
		else $error("allowed class refused");
	chk_start_vector: assert property (
		host_signal_in && (run_out || !started_q) |-> ##[1:4]
		mem_req_out && !mem_we_out
		&& mem_addr_out == ADDR_W'(ats_pkg::VEC_START))
		else $error("start vector not fetched");
	chk_req_hold: assert property (
		mem_req_out && !mem_ack_in |=> mem_req_out
		&& $stable(mem_addr_out) && $stable(mem_we_out)
		&& $stable(mem_wdata_out))
		else $error("memory request changed before ack");
	chk_new_dw_data: assert property (
		new_dw_load_out |-> new_dw_out == {rd1_q, rd0_q})
		else $error("new doubleword not words 3 and 4");
	chk_run_after: assert property (
		new_dw_load_out |-> ##[0:1] run_out)
		else $error("no run after load");
	chk_done_order: assert property (
		host_done_out |-> !run_out && !new_dw_load_out
		##1 !host_done_out)
		else $error("done pulse out of place");
	chk_status_reply: assert property (
		read_status_in |=> status_valid_out && status_out[0]
		&& status_reg_out == $past(read_status_reg_in)
		&& status_out[7:5] == {$past(arith_en_in),
		$past(traps_off_in), $past(block_mode_in)})
		else $error("status reply wrong");
	chk_flags_clear: assert property (
		read_status_in && err_flags_in == 24'h0 && !instr_refused_out
		&& !error_trap_in ##1 err_flags_in == 24'h0 && !instr_refused_out
		##1 read_status_in |=> status_out[31:8] == 24'h0)
		else $error("flags not cleared by report");
	chk_flags_kept: assert property (
		read_status_in && err_flags_in != 24'h0 ##2 read_status_in
		|=> (status_out[31:8] & $past(err_flags_in, 3))
		== $past(err_flags_in, 3))
		else $error("flag lost in report cycle");
endmodule // ats_trap_seq_sva

bind ats_trap_seq ats_trap_seq_sva #(.ADDR_W(ADDR_W))
	ats_trap_seq_sva_inst (.*);

// [tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin \
	checked++; \
	if ((gt) !== (ex)) begin \
		mismatches++; \
		$display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
	end \
end
module tb_top;
	localparam logic [23:0] C_START = 24'h001000;
	localparam logic [23:0] C_ERR   = 24'h001100;
	localparam logic [23:0] C_MON   = 24'h001200;
	localparam logic [23:0] C_STOP  = 24'h001300;
	localparam logic [23:0] C_SUPV  = 24'h001400;
	localparam logic [23:0] T_SUPV  = 24'h002000;
	localparam logic [23:0] UNDEF   = 24'h1 << (ats_pkg::FLAG_UNDEF_BIT -
		ats_pkg::STAT_FLAG_LSB);
	logic mclk_in, rst_in, host_signal_in, instr_valid_in, error_trap_in;
	logic supv_call_in, monitor_call_in, stop_signal_in, read_status_in;
	logic block_mode_in, traps_off_in, arith_en_in, mem_ack_in, run_out;
	logic instr_refused_out, new_dw_load_out, status_valid_out;
	logic host_done_out, mem_req_out, mem_we_out;
	logic [2:0]  read_status_reg_in, status_reg_out;
	logic [3:0]  lat;
	logic [23:0] err_flags_in, mem_addr_out;
	logic [31:0] instr_word_in, status_out, mem_wdata_out, mem_rdata_in;
	logic [63:0] cur_dw_in, new_dw_out;
	ats_pkg::ats_op_e instr_class_in;
	int          mismatches, checked, cycles;

	ats_trap_seq #(.ADDR_W(24)) ats_trap_seq_inst (.*);
	ats_mem_model #(.ADDR_W(24)) ats_mem_model_inst (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.req_in    (mem_req_out),
		.we_in     (mem_we_out),
		.addr_in   (mem_addr_out),
		.wdata_in  (mem_wdata_out),
		.lat_in    (lat),
		.ack_out   (mem_ack_in),
		.rdata_out (mem_rdata_in)
	);

	always #5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic finish_test();
		if (mismatches == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	function automatic logic [31:0] stat(input logic [23:0] f);
		stat = {f, arith_en_in, traps_off_in, block_mode_in, 4'h0, 1'b1};
	endfunction
	task automatic put(input logic [23:0] a, input logic [31:0] d);
		ats_mem_model_inst.mem[a] = d;
	endtask
	task automatic cause(input int k, input logic v);
		host_signal_in  <= v && k == 0;
		stop_signal_in  <= v && k == 1;
		monitor_call_in <= v && k == 2;
		supv_call_in    <= v && k == 3;
		instr_valid_in  <= v && k inside {[4:6]};
		error_trap_in   <= v && k == 7;
	endtask
	task automatic rd_status(input logic [2:0] r, input logic [23:0] e,
			input logic [23:0] ex);
		@(posedge mclk_in);
		read_status_in     <= 1'b1;
		read_status_reg_in <= r;
		err_flags_in       <= e;
		@(posedge mclk_in);
		read_status_in <= 1'b0;
		err_flags_in   <= 24'h0;
		@(negedge mclk_in);
		`CHK("status valid", 1'b1, status_valid_out)
		`CHK("status reg", r, status_reg_out)
		`CHK("status word", stat(ex), status_out)
	endtask
	task automatic trap(input int k, input logic [23:0] ctx,
			input logic [23:0] fl, input logic dn_ex);
		logic [63:0] old;
		int n;
		int dn;
		old = {8'h5a, ctx, 8'ha5, ctx};
		put(ctx + 24'h8, ~old[63:32]);
		put(ctx + 24'hc, ~old[31:0]);
		@(posedge mclk_in);
		cur_dw_in     <= old;
		instr_word_in <= 32'h0000f000;
		err_flags_in  <= (k == 0 || k == 7) ? fl : 24'h0;
		if (k inside {[4:6]}) begin
			instr_class_in <= ats_pkg::ats_op_e'(k - 3);
		end
		cause(k, 1'b1);
		if (k inside {[4:6]}) begin
			@(negedge mclk_in);
			`CHK("refused", 1'b1, instr_refused_out)
		end
		@(posedge mclk_in);
		cause(k, 1'b0);
		err_flags_in <= 24'h0;
		n  = 0;
		dn = 0;
		while (new_dw_load_out !== 1'b1 && n < 300) begin
			@(negedge mclk_in);
			n++;
			dn += (host_done_out === 1'b1 && new_dw_load_out !== 1'b1);
		end
		`CHK("new dw", ~old, new_dw_out)
		`CHK("old high", old[63:32], ats_mem_model_inst.mem[ctx])
		`CHK("old low", old[31:0], ats_mem_model_inst.mem[ctx + 24'h4])
		`CHK("word5", stat(fl), ats_mem_model_inst.mem[ctx + 24'h10])
		`CHK("done count", dn_ex ? 1 : 0, dn)
		@(negedge mclk_in);
		`CHK("running", 1'b1, run_out)
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_quiet();
		int n;
		n = 0;
		instr_class_in <= ats_pkg::ATS_OP_INTRET;
		for (int k = 1; k < 8; k++) begin
			@(posedge mclk_in);
			cause(k, 1'b1);
			@(posedge mclk_in);
			cause(k, 1'b0);
			repeat (3) begin
				@(negedge mclk_in);
				if ({mem_req_out, run_out, host_done_out, instr_refused_out}
						!== 4'h0) begin
					n++;
				end
			end
		end
		`CHK("idle activity", 0, n)
	endtask
	task automatic t_status();
		rd_status(3'h5, 24'h800001, 24'h0);
		rd_status(3'h2, 24'h0, 24'h800001);
		{arith_en_in, traps_off_in, block_mode_in} <= 3'h2;
		rd_status(3'h7, 24'h0, 24'h0);
		{arith_en_in, traps_off_in, block_mode_in} <= 3'h5;
	endtask
	task automatic t_start();
		trap(0, C_START, 24'h000c03, 1'b0);
		rd_status(3'h1, 24'h0, 24'h0);
	endtask
	task automatic t_codes();
		lat <= 4'h2;
		for (int k = 4; k < 7; k++) begin
			trap(k, C_ERR, UNDEF, 1'b0);
		end
		trap(7, C_ERR, 24'h000010, 1'b0);
		trap(2, C_MON, 24'h0, 1'b0);
		trap(3, C_SUPV, 24'h0, 1'b0);
	endtask
	task automatic t_allowed();
		for (int c = 0; c < 2; c++) begin
			@(posedge mclk_in);
			instr_valid_in <= 1'b1;
			instr_class_in <= c ? ats_pkg::ATS_OP_UNBLOCK : ats_pkg::ATS_OP_PLAIN;
			@(negedge mclk_in);
			`CHK("not refused", 1'b0, instr_refused_out)
		end
		@(posedge mclk_in);
		instr_valid_in <= 1'b0;
		repeat (4) @(negedge mclk_in);
		`CHK("no trap", 1'b0, mem_req_out)
	endtask

	initial begin
		{mclk_in, host_signal_in, instr_valid_in, error_trap_in} = 4'h0;
		{supv_call_in, monitor_call_in, stop_signal_in} = 3'h0;
		{read_status_in, traps_off_in} = 2'h0;
		{block_mode_in, arith_en_in, rst_in} = 3'h7;
		read_status_reg_in = 3'h0;
		lat = 4'h0;
		err_flags_in = 24'h0;
		instr_word_in = 32'h0;
		cur_dw_in = 64'h0;
		instr_class_in = ats_pkg::ATS_OP_PLAIN;
		put({12'h0, ats_pkg::VEC_START}, C_START | 24'h3);
		put({12'h0, ats_pkg::VEC_SUPV}, T_SUPV);
		put({12'h0, ats_pkg::VEC_ERROR}, C_ERR);
		put({12'h0, ats_pkg::VEC_MONITOR}, C_MON);
		put({12'h0, ats_pkg::VEC_STOP}, C_STOP);
		put(T_SUPV + 24'h3c, C_SUPV);
		repeat (6) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_quiet();
		t_status();
		t_start();
		t_allowed();
		t_codes();
		trap(1, C_STOP, 24'h0, 1'b1);
		trap(0, C_START, 24'h0, 1'b0);
		@(posedge mclk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_quiet();
		finish_test();
	end
endmodule // tb_top
